/* File: pm_event_shadow_regs.svh */
// pm_event_shadow_regs.svh: offsets, field positions, reset values and times
// assumes: included by bare name from the design files of this group
`ifndef PM_EVENT_SHADOW_REGS_SVH
`define PM_EVENT_SHADOW_REGS_SVH

// i/o port addresses
`define PM_NMI_STATUS_ADDR      16'h9072
`define PM_SP_SHADOW_ADDR       16'hD072
`define PM_INTC_SHADOW_ADDR     16'hD472
`define PM_RTC_SHADOW_ADDR      16'hE472
`define PM_RTC_INDEX_PORT       16'h0070

// field positions
`define PM_NMI_FLAGS_LSB        2
`define PM_RTC_NMI_DIS_BIT      7
`define PM_RTC_FIX_BIT          11
`define PM_SNOOP_INDEX_MSB      6
`define PM_FIRST_EVENT_LINE     2
`define PM_EDGE_ONLY_LINE       7

// reset values
`define PM_RESET_WORD           16'h0000
`define PM_RESET_EVENTS         6'h00
`define PM_RESET_INDEX          7'h00
`define PM_RESET_NMI_DIS        1'b1
`define PM_RESET_FIX            1'b0

// timing
`define PM_CLK_PERIOD_NS        10
`define PM_NO_DMA_WINDOW_NS     30500

`endif

/* File: pm_types_pkg.sv */
// pm_types_pkg: shared types of the power-management status and shadow group
// assumes: referenced as pm_types_pkg::name, never imported
package pm_types_pkg;

   // one-hot register select for the read decode
   typedef enum logic [4:0] {
      SEL_NONE = 5'b0_0001,
      SEL_NMI  = 5'b0_0010,
      SEL_SP   = 5'b0_0100,
      SEL_INTC = 5'b0_1000,
      SEL_RTC  = 5'b1_0000
   } reg_sel_t;

endpackage

/* File: pm_sync2.sv */
// pm_sync2: two-flop synchroniser for pins entering the core clock domain
// assumes: each bit is an independent level; no bus coherence needed
`timescale 1ns/1ns
module pm_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule // pm_sync2

/* File: pm_input_channel.sv */
// pm_input_channel: event detect, status latch and source flags for one input
// assumes: line is already synchronised; enables come from same-clock logic
`timescale 1ns/1ns
module pm_input_channel #(
   parameter bit EDGE_ONLY = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic line,
   input  wire logic nmi_en,
   input  wire logic attn_en,
   output logic      nmi_flag,
   output logic      attn_flag,
   output logic      status
);
   logic prev;
   logic event_seen;
   logic idle;

   // inputs 2..6 fire on any change, input 7 on its rising edge only
   assign event_seen = EDGE_ONLY ? (line & ~prev) : (line ^ prev);
   assign idle       = ~nmi_en & ~attn_en;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev <= 1'b0;
      end else begin
         prev <= line;
      end
   end

   // flags clear only once both enables are down; writes never touch them
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         nmi_flag  <= 1'b0;
         attn_flag <= 1'b0;
      end else if (idle) begin
         nmi_flag  <= 1'b0;
         attn_flag <= 1'b0;
      end else begin
         nmi_flag  <= nmi_flag | (event_seen & nmi_en);
         attn_flag <= attn_flag | (event_seen & attn_en);
      end
   end

   // unlatched status follows the line, latched status holds a transition
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= 1'b0;
      end else if (idle) begin
         status <= line;
      end else begin
         status <= status | event_seen;
      end
   end
endmodule // pm_input_channel

/* File: pm_event_shadow_regs.sv */
// pm_event_shadow_regs: power-management event flags and read-only shadows
// assumes: 16-bit i/o cycles as single-cycle strobes on core_clk; enable
// registers, serial/parallel ports and interrupt controllers live elsewhere
// and present their state as same-clock levels.
//
// Contract
// - enabled input change raises attention, maybe SMI; code fires input 7 on its rising edge only
// - enable register bits 1:0 ignored
// - NMI flags record which input caused NMI
// - flags clear only via enable reset
// - both enables reset before status clears
// - serial/parallel shadow read-only, no reset value
// - bits 15:12 mirror serial control bits 7:6
// - bits 11:0 mirror parallel registers 2, 0
// - interrupt controller shadow is read-only
// - bit 15 shows live monitor timeout
// - bits 14:13 hold fixed part code
// - bits 12:11 show vector bit 7
// - bits 10:9 show master init word four
// - bit 8 shows rotate on auto end
// - bits 7:2 show bottom priority levels
// - bits 1:0 show special mask mode
// - RTC shadow readable while locked
// - RTC shadow bit 11 only writable
// - bit 15 is reference divided by two
// - bit 14 copies refresh toggle
// - bit 13 shows CPU interrupt line
// - bit 12 reports recent DMA activity
// - bit 11 plain storage, write needs unlock
// - bits 7:0 capture last index port write
`timescale 1ns/1ns
`include "pm_event_shadow_regs.svh"
module pm_event_shadow_regs #(
   parameter logic [1:0] PART_CODE = 2'b10 // arbitrary value
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // i/o port access
   input  wire logic [15:0] io_addr,
   input  wire logic [15:0] io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic        regs_unlocked,
   output logic      [15:0] io_rdata,
   output logic             io_rd_hit,
   // power-control pins and enables
   input  wire logic [7:0]  power_control,
   input  wire logic [5:0]  nmi_enable_bits,
   input  wire logic [5:0]  attention_enable_bits,
   input  wire logic        attention_smi_enable,
   // shadow sources
   input  wire logic [7:0]  serial_a_ctl2,
   input  wire logic [7:0]  serial_b_ctl2,
   input  wire logic [7:0]  parallel_ctl2,
   input  wire logic [7:0]  parallel_data0,
   input  wire logic        monitor_timeout_live,
   input  wire logic        master_vector_bit7,
   input  wire logic        slave_vector_bit7,
   input  wire logic        special_nesting,
   input  wire logic        auto_end_irq,
   input  wire logic        rotate_auto_end,
   input  wire logic [2:0]  master_bottom_priority,
   input  wire logic [2:0]  slave_bottom_priority,
   input  wire logic        master_special_masking,
   input  wire logic        slave_special_masking,
   // status sources
   input  wire logic        refresh_reference_input,
   input  wire logic        refresh_toggle,
   input  wire logic        cpu_irq_line,
   input  wire logic        dma_cycle,
   // event outputs
   output logic             local_attention,
   output logic             smi_request,
   output logic             nmi_request,
   output logic      [5:0]  nmi_source_flags,
   output logic      [5:0]  attention_source_flags,
   output logic      [7:0]  sampled_line_flags
);

   localparam int DMA_IDLE_CYCLES =
      (`PM_NO_DMA_WINDOW_NS + `PM_CLK_PERIOD_NS - 1) / `PM_CLK_PERIOD_NS;
   localparam logic [11:0] DMA_IDLE_LIMIT = 12'(DMA_IDLE_CYCLES);
   localparam int          EVENT_LINES    = 6;

   // synchronised pins
   logic [7:0]  line_sync;
   logic        ref_sync;

   // per-input results
   logic [5:0]  chan_nmi;
   logic [5:0]  chan_attn;
   logic [5:0]  chan_status;

   // status word sources
   logic        ref_prev;
   logic        slow_reference_tick;
   logic [11:0] dma_quiet_count;
   logic        dma_idle;
   logic        clock_fix_flag;
   logic        nmi_disable_copy;
   logic [6:0]  rtc_index_copy;
   logic        index_wr;
   logic        fix_wr;

   // read-side assembly
   pm_types_pkg::reg_sel_t sel;
   logic [15:0] nmi_word;
   logic [15:0] sp_word;
   logic [15:0] intc_word;
   logic [15:0] rtc_word;
   logic [15:0] next_rdata;
   logic        next_hit;

   // pins change outside the clock domain
   pm_sync2 #(
      .WIDTH    (8)
   ) u_line_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in (power_control),
      .sync_out (line_sync)
   );

   pm_sync2 #(
      .WIDTH    (1)
   ) u_ref_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in (refresh_reference_input),
      .sync_out (ref_sync)
   );

   // enable bits map one to one on lines 2..7; enable bits 1:0 of the
   // enable register never arrive here, so writes to them have no effect
   genvar gi;
   generate
      for (gi = 0; gi < EVENT_LINES; gi++) begin : g_chan
         pm_input_channel #(
            .EDGE_ONLY (gi + `PM_FIRST_EVENT_LINE == `PM_EDGE_ONLY_LINE)
         ) u_chan (
            .core_clk  (core_clk),
            .rst_b     (rst_b),
            .line      (line_sync[gi + `PM_FIRST_EVENT_LINE]),
            .nmi_en    (nmi_enable_bits[gi]),
            .attn_en   (attention_enable_bits[gi]),
            .nmi_flag  (chan_nmi[gi]),
            .attn_flag (chan_attn[gi]),
            .status    (chan_status[gi])
         );
      end
   endgenerate

   // event outputs, registered once more so every port leaves a flip-flop
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         local_attention        <= 1'b0;
         attention_source_flags <= `PM_RESET_EVENTS;
      end else begin
         local_attention        <= |chan_attn;
         attention_source_flags <= chan_attn;
      end
   end

   // smi uses the enable as it stands one cycle before the output moves
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         smi_request <= 1'b0;
      end else begin
         smi_request <= (|chan_attn) & attention_smi_enable;
      end
   end

   // nmi side kept apart from attention; either may be enabled alone
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         nmi_request      <= 1'b0;
         nmi_source_flags <= `PM_RESET_EVENTS;
      end else begin
         nmi_request      <= |chan_nmi;
         nmi_source_flags <= chan_nmi;
      end
   end

   // lines 1:0 only show the present level
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sampled_line_flags <= 8'h00;
      end else begin
         sampled_line_flags <= {chan_status, line_sync[1:0]};
      end
   end

   // reference divided by two; follows the pin, not refresh programming
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_prev <= 1'b0;
      end else begin
         ref_prev <= ref_sync;
      end
   end

   // one toggle per rising reference edge gives the half rate
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slow_reference_tick <= 1'b0;
      end else if (ref_sync & ~ref_prev) begin
         slow_reference_tick <= ~slow_reference_tick;
      end
   end

   // one threshold serves both limits: idle reads 1 only after a full
   // quiet window, and any cycle inside that window forces 0
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_quiet_count <= 12'h000;
      end else if (dma_cycle) begin
         dma_quiet_count <= 12'h000;
      end else if (dma_quiet_count != DMA_IDLE_LIMIT) begin
         dma_quiet_count <= dma_quiet_count + 12'h001;
      end
   end

   // idle drops on the same edge that samples any dma activity
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_idle <= 1'b0;
      end else begin
         dma_idle <= ~dma_cycle & (dma_quiet_count == DMA_IDLE_LIMIT);
      end
   end

   // write strobes that land in this group
   assign fix_wr   = io_wr & regs_unlocked & (io_addr == `PM_RTC_SHADOW_ADDR);
   assign index_wr = io_wr & (io_addr == `PM_RTC_INDEX_PORT);

   // storage bit: readable always, writable only while unlocked
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clock_fix_flag <= `PM_RESET_FIX;
      end else if (fix_wr) begin
         clock_fix_flag <= io_wdata[`PM_RTC_FIX_BIT];
      end
   end

   // snoop the write-only index port; lock state does not matter here
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         nmi_disable_copy <= `PM_RESET_NMI_DIS;
      end else if (index_wr) begin
         nmi_disable_copy <= io_wdata[`PM_RTC_NMI_DIS_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rtc_index_copy <= `PM_RESET_INDEX;
      end else if (index_wr) begin
         rtc_index_copy <= io_wdata[`PM_SNOOP_INDEX_MSB:0];
      end
   end

   // serial/parallel and interrupt controller shadows are live views of their sources, no stale copy to drift
   assign nmi_word  = {8'h00, chan_nmi, 2'b00};
   assign sp_word   = {serial_a_ctl2[7:6], serial_b_ctl2[7:6],
                       parallel_ctl2[3:0], parallel_data0};
   assign intc_word = {monitor_timeout_live,
                       PART_CODE,
                       master_vector_bit7, slave_vector_bit7,
                       special_nesting, auto_end_irq,
                       rotate_auto_end,
                       master_bottom_priority, slave_bottom_priority,
                       master_special_masking, slave_special_masking};
   assign rtc_word  = {slow_reference_tick,
                       refresh_toggle,
                       cpu_irq_line,
                       dma_idle,
                       clock_fix_flag,
                       3'b000,
                       nmi_disable_copy, rtc_index_copy};

   // address decode
   always_comb begin
      unique case (io_addr)
         `PM_NMI_STATUS_ADDR:  sel = pm_types_pkg::SEL_NMI;
         `PM_SP_SHADOW_ADDR:   sel = pm_types_pkg::SEL_SP;
         `PM_INTC_SHADOW_ADDR: sel = pm_types_pkg::SEL_INTC;
         `PM_RTC_SHADOW_ADDR:  sel = pm_types_pkg::SEL_RTC;
         default:              sel = pm_types_pkg::SEL_NONE;
      endcase
   end

   // locked reads of the guarded words return zero without a hit;
   // the status word stays open because it is polled often
   always_comb begin
      next_rdata = `PM_RESET_WORD;
      next_hit   = 1'b0;
      unique case (sel)
         pm_types_pkg::SEL_NMI: begin
            next_rdata = regs_unlocked ? nmi_word : `PM_RESET_WORD;
            next_hit   = regs_unlocked;
         end
         pm_types_pkg::SEL_SP: begin
            next_rdata = regs_unlocked ? sp_word : `PM_RESET_WORD;
            next_hit   = regs_unlocked;
         end
         pm_types_pkg::SEL_INTC: begin
            next_rdata = regs_unlocked ? intc_word : `PM_RESET_WORD;
            next_hit   = regs_unlocked;
         end
         pm_types_pkg::SEL_RTC: begin
            next_rdata = rtc_word;
            next_hit   = 1'b1;
         end
         pm_types_pkg::SEL_NONE: begin
            next_rdata = `PM_RESET_WORD;
            next_hit   = 1'b0;
         end
      endcase
   end

   // read data holds until the next read; writes to the read-only words
   // and to the flag word fall through with no effect
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         io_rdata <= `PM_RESET_WORD;
      end else if (io_rd) begin
         io_rdata <= next_rdata;
      end
   end

   // hit is a one-cycle pulse, so it follows the strobe every cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         io_rd_hit <= 1'b0;
      end else begin
         io_rd_hit <= io_rd & next_hit;
      end
   end

endmodule // pm_event_shadow_regs

/* File: pm_event_shadow_regs_assertions.sv */
// pm_event_shadow_regs_assertions.sv: port checker for the event and shadow group
// assumes: one core_clk domain; host strobes are one-cycle pulses
`timescale 1ns/1ns
`include "pm_event_shadow_regs.svh"
module pm_event_shadow_regs_chk #(
   parameter logic [1:0] PART_CODE = 2'b10
) (
   input wire logic        core_clk,
   input wire logic        rst_b,
   input wire logic [15:0] io_addr,
   input wire logic [15:0] io_wdata,
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic        regs_unlocked,
   input wire logic [15:0] io_rdata,
   input wire logic [5:0]  nmi_enable_bits,
   input wire logic [5:0]  attention_enable_bits,
   input wire logic        attention_smi_enable,
   input wire logic        local_attention,
   input wire logic        smi_request,
   input wire logic [5:0]  nmi_source_flags,
   input wire logic [5:0]  attention_source_flags,
   input wire logic        refresh_toggle,
   input wire logic        cpu_irq_line,
   input wire logic        dma_cycle
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic [5:0] kept;
   logic [5:0] prev_attn;
   logic [5:0] prev_aen;
   assign kept = nmi_source_flags & (nmi_enable_bits | attention_enable_bits);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_attn <= 6'h00;
         prev_aen  <= 6'h00;
      end else begin
         prev_attn <= attention_source_flags;
         prev_aen  <= attention_enable_bits;
      end
   end
   sequence rtc_read;
      io_rd && io_addr == `PM_RTC_SHADOW_ADDR;
   endsequence
   sequence fix_write;
      io_wr && io_addr == `PM_RTC_SHADOW_ADDR && regs_unlocked;
   endsequence
   sequence index_write;
      io_wr && io_addr == `PM_RTC_INDEX_PORT;
   endsequence
   chk_nmi_zero_bits: assert property (
      io_rd && io_addr == `PM_NMI_STATUS_ADDR |=> io_rdata[15:8] == 8'h00 && io_rdata[1:0] == 2'b00)
      else $error("nmi status unused bits not zero");
   chk_part_code: assert property (
      io_rd && io_addr == `PM_INTC_SHADOW_ADDR && regs_unlocked |=> io_rdata[14:13] == PART_CODE)
      else $error("part code field wrong");
   chk_rtc_live_bits: assert property (
      rtc_read |=> io_rdata[14] == $past(refresh_toggle) && io_rdata[13] == $past(cpu_irq_line))
      else $error("rtc shadow live bits wrong");
   chk_index_capture: assert property (
      index_write ##2 rtc_read |=> io_rdata[7:0] == $past(io_wdata[7:0], 3))
      else $error("index port copy wrong");
   chk_fix_bit_write: assert property (
      fix_write ##2 rtc_read |=> io_rdata[11] == $past(io_wdata[11], 3))
      else $error("storage bit not written");
   chk_fix_bit_locked: assert property (
      rtc_read ##2 (io_wr && io_addr == `PM_RTC_SHADOW_ADDR && !regs_unlocked) ##2 rtc_read
      |=> io_rdata[11] == $past(io_rdata[11]))
      else $error("storage bit written while locked");
   chk_flags_hold: assert property (
      |kept |=> (nmi_source_flags & $past(kept)) == $past(kept))
      else $error("nmi flag lost while enabled");
   chk_attn_needs_en: assert property (
      ((attention_source_flags & ~prev_attn) & ~prev_aen) == 6'h00)
      else $error("attention flag set without enable");
   chk_attn_raises: assert property (
      (|attention_source_flags)[*3] |-> local_attention && (smi_request == $past(attention_smi_enable)))
      else $error("attention or smi output wrong");
   chk_dma_recent: assert property (
      dma_cycle ##[1:3] rtc_read |=> !io_rdata[12])
      else $error("dma idle bit set after dma cycle");
endmodule // pm_event_shadow_regs_chk

bind pm_event_shadow_regs pm_event_shadow_regs_chk #(.PART_CODE(PART_CODE)) chk_i (.*);

/* File: pm_host_model.sv */
// pm_host_model.sv: host software side issuing 16-bit i/o cycles
// assumes: strobe taken on the rising edge, answer valid one edge later
`timescale 1ns/1ns
module pm_host_model (
   input  wire logic        core_clk,
   input  wire logic [15:0] io_rdata,
   input  wire logic        io_rd_hit,
   output logic      [15:0] io_addr,
   output logic      [15:0] io_wdata,
   output logic             io_wr,
   output logic             io_rd
);
   initial begin
      io_addr  = 16'h0000;
      io_wdata = 16'h0000;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      io_addr  <= a;
      io_wdata <= d;
      io_wr    <= 1'b1;
      @(posedge core_clk);
      io_wr    <= 1'b0;
   endtask
   // sampled mid-cycle so the registered answer has settled
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic h);
      @(posedge core_clk);
      io_addr <= a;
      io_rd   <= 1'b1;
      @(posedge core_clk);
      io_rd   <= 1'b0;
      @(negedge core_clk);
      d = io_rdata;
      h = io_rd_hit;
   endtask
endmodule // pm_host_model

/* File: tb.sv */
// tb.sv: self-checking bench of the event and shadow group
// assumes: host model issues all i/o cycles; checker bound separately
`timescale 1ns/1ns
`include "pm_event_shadow_regs.svh"
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb;
   localparam logic [1:0] PART = 2'b01; // arbitrary value
   logic        core_clk, rst_b, regs_unlocked, io_rd_hit, io_wr, io_rd, h, v;
   logic [15:0] io_addr, io_wdata, io_rdata, d, p;
   logic [7:0]  power_control, serial_a_ctl2, serial_b_ctl2, parallel_ctl2, parallel_data0;
   logic [7:0]  sampled_line_flags;
   logic [5:0]  nmi_enable_bits, attention_enable_bits, nmi_source_flags, attention_source_flags, m;
   logic [2:0]  master_bottom_priority, slave_bottom_priority;
   logic        attention_smi_enable, monitor_timeout_live, master_vector_bit7, slave_vector_bit7;
   logic        special_nesting, auto_end_irq, rotate_auto_end, master_special_masking;
   logic        slave_special_masking, refresh_reference_input, refresh_toggle, cpu_irq_line;
   logic        dma_cycle, local_attention, smi_request, nmi_request;
   int          num_checks, bad_count, cyc;

   pm_event_shadow_regs #(.PART_CODE(PART)) pm_event_shadow_regs_i (.*);
   pm_host_model pm_host_model_i (.*);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // long enough for the 3050-cycle idle window plus all event walks
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         close_out();
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] mk, input logic [15:0] e,
                         input string what);
      pm_host_model_i.rd(a, d, h);
      `CHK(what, e, d & mk)
   endtask
   task automatic set_en(input logic [5:0] n, input logic [5:0] a, input logic s);
      @(posedge core_clk);
      nmi_enable_bits       <= n;
      attention_enable_bits <= a;
      attention_smi_enable  <= s;
   endtask
   task automatic t_shadow;
      for (int i = 0; i < 2; i++) begin
         p = i ? 16'h5a3c : 16'ha5c3;
         @(posedge core_clk);
         serial_a_ctl2  <= p[15:8];
         serial_b_ctl2  <= p[7:0];
         parallel_ctl2  <= p[11:4];
         parallel_data0 <= ~p[7:0];
         {monitor_timeout_live, master_vector_bit7, slave_vector_bit7, special_nesting,
          auto_end_irq, rotate_auto_end, master_bottom_priority, slave_bottom_priority,
          master_special_masking, slave_special_masking} <= p[15:2];
         rd_chk(`PM_SP_SHADOW_ADDR, 16'hffff, {p[15:14], p[7:6], p[7:4], ~p[7:0]}, "sp");
         `CHK("sp hit", 1'b1, h)
         rd_chk(`PM_INTC_SHADOW_ADDR, 16'hffff, {p[15], PART, p[14:2]}, "intc");
         pm_host_model_i.wr(`PM_SP_SHADOW_ADDR, ~p);
         pm_host_model_i.wr(`PM_INTC_SHADOW_ADDR, ~p);
         rd_chk(`PM_SP_SHADOW_ADDR, 16'hffff, {p[15:14], p[7:6], p[7:4], ~p[7:0]}, "sp ro");
         rd_chk(`PM_INTC_SHADOW_ADDR, 16'hffff, {p[15], PART, p[14:2]}, "intc ro");
      end
   endtask
   task automatic t_rtc;
      rd_chk(`PM_RTC_SHADOW_ADDR, 16'h0f80, 16'h0080, "rtc reset");
      @(posedge core_clk) regs_unlocked <= 1'b0;
      pm_host_model_i.wr(`PM_RTC_INDEX_PORT, 16'h00c5);
      rd_chk(`PM_RTC_SHADOW_ADDR, 16'h00ff, 16'h00c5, "rtc index");
      `CHK("rtc hit", 1'b1, h)
      pm_host_model_i.wr(`PM_RTC_SHADOW_ADDR, 16'hffff);
      rd_chk(`PM_RTC_SHADOW_ADDR, 16'h0fff, 16'h00c5, "locked write");
      @(posedge core_clk) regs_unlocked <= 1'b1;
      pm_host_model_i.wr(`PM_RTC_SHADOW_ADDR, 16'hffff);
      rd_chk(`PM_RTC_SHADOW_ADDR, 16'h0fff, 16'h08c5, "unlocked write");
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         refresh_toggle <= i[0];
         cpu_irq_line   <= !i[0];
         rd_chk(`PM_RTC_SHADOW_ADDR, 16'h6000, {1'b0, i[0], !i[0], 13'h0}, "live bits");
      end
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk) refresh_reference_input <= 1'b0;
         wait_cyc(5);
         @(posedge core_clk) refresh_reference_input <= 1'b1;
         wait_cyc(5);
         pm_host_model_i.rd(`PM_RTC_SHADOW_ADDR, d, h);
         if (i == 1)
            `CHK("ref half rate", !v, d[15])
         v = d[15];
      end
   endtask
   task automatic t_events;
      for (int k = 2; k < 8; k++) begin
         m = 6'b00_0001 << (k - 2);
         set_en(m, 6'h00, 1'b0);
         @(posedge core_clk) power_control[k] <= 1'b1;
         wait_cyc(8);
         `CHK("nmi flags", m, nmi_source_flags)
         `CHK("attn idle", 6'h00, attention_source_flags)
         `CHK("nmi out", 1'b1, nmi_request)
         `CHK("line latched", 1'b1, sampled_line_flags[k])
         pm_host_model_i.wr(`PM_NMI_STATUS_ADDR, 16'h0000);
         rd_chk(`PM_NMI_STATUS_ADDR, 16'hffff, {8'h00, m, 2'b00}, "nmi status");
         set_en(m, m, 1'b1);
         @(posedge core_clk) power_control[k] <= 1'b0;
         wait_cyc(8);
         `CHK("attn flags", (k < 7) ? m : 6'h00, attention_source_flags)
         `CHK("smi out", k < 7, smi_request)
         `CHK("attn out", k < 7, local_attention)
         set_en(6'h00, m, 1'b0);
         wait_cyc(3);
         `CHK("nmi held", m, nmi_source_flags)
         set_en(6'h00, 6'h00, 1'b0);
         wait_cyc(3);
         `CHK("nmi cleared", 6'h00, nmi_source_flags)
         `CHK("attn cleared", 6'h00, attention_source_flags)
         `CHK("line unlatched", 1'b0, sampled_line_flags[k])
      end
      set_en(6'h3f, 6'h3f, 1'b0);
      @(posedge core_clk) power_control[1:0] <= 2'b11;
      wait_cyc(8);
      `CHK("low lines", 6'h00, nmi_source_flags | attention_source_flags)
      `CHK("low levels", 2'b11, sampled_line_flags[1:0])
      set_en(6'h00, 6'h00, 1'b0);
   endtask
   task automatic t_dma;
      @(posedge core_clk) dma_cycle <= 1'b1;
      @(posedge core_clk) dma_cycle <= 1'b0;
      rd_chk(`PM_RTC_SHADOW_ADDR, 16'h1000, 16'h0000, "dma recent");
      wait_cyc(3060);
      rd_chk(`PM_RTC_SHADOW_ADDR, 16'h1000, 16'h1000, "dma idle");
   endtask
   initial begin
      {power_control, serial_a_ctl2, serial_b_ctl2, parallel_ctl2, parallel_data0} = '0;
      {nmi_enable_bits, attention_enable_bits, master_bottom_priority, slave_bottom_priority} = '0;
      {attention_smi_enable, monitor_timeout_live, master_vector_bit7, slave_vector_bit7} = '0;
      {special_nesting, auto_end_irq, rotate_auto_end, master_special_masking} = '0;
      {slave_special_masking, refresh_reference_input, refresh_toggle, cpu_irq_line} = '0;
      {dma_cycle, v} = '0;
      regs_unlocked = 1'b1;
      rst_b = 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      rd_chk(`PM_NMI_STATUS_ADDR, 16'hffff, 16'h0000, "nmi reset");
      t_rtc();
      t_shadow();
      t_events();
      t_dma();
      close_out();
   end
endmodule // tb
